// [bench/itmr_cpu_model.sv]
module itmr_cpu_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic oe_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [1:0] port_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: strobes high, data parked
  initial {cs_n_o, rd_n_o, wr_n_o, port_o, wdata_o} = 13'h1fff;
  // Write taken on one edge; data inverted after release to hide stale bytes
  task automatic bus_wr(input logic cs_n, input logic [1:0] p,
    input logic [7:0] d);
    @(negedge mclk_i);
    {cs_n_o, wr_n_o, port_o, wdata_o} = {cs_n, 1'b0, p, d};
    @(posedge mclk_i);
    @(negedge mclk_i);
    {cs_n_o, wr_n_o, wdata_o} = {2'h3, ~d};
  endtask
  // Read held over two edges, answer sampled once settled
  task automatic bus_rd(input logic [1:0] p, output logic [7:0] d,
    output logic oe);
    @(negedge mclk_i);
    {cs_n_o, rd_n_o, port_o} = {2'h0, p};
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    d = rdata_i;
    oe = oe_i;
    {cs_n_o, rd_n_o} = 2'h3;
  endtask
endmodule

// [bench/itmr_host_if_assertions.sv]
module itmr_host_if_assertions (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_select_hi_i,
  input wire logic port_select_lo_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_act;
  logic ctl;
  // Qualified read strobe and control port decode
  assign rd_act = !cs_n_i && !rd_n_i;
  assign ctl = port_select_hi_i && port_select_lo_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_read_drives: assert property (
    $rose(rd_act) && !ctl |=> data_oe_o)
    else $error("counter read not driven");
  a_ctrl_floats: assert property (rd_act && ctl |=> !data_oe_o)
    else $error("control port read drove bus");
  a_cs_ignored: assert property (cs_n_i |=> !data_oe_o)
    else $error("bus driven while deselected");
  a_cs_no_data: assert property (
    cs_n_i && !wr_n_i |=> $stable(data_o))
    else $error("deselected strobe changed data");
  a_rd_release: assert property (rd_n_i |=> !data_oe_o)
    else $error("bus held after read");
  a_data_holds: assert property (
    rd_n_i && $past(rd_n_i) |=> $stable(data_o))
    else $error("read data changed without read");
  a_oe_holds: assert property (
    $rose(rd_act) && !ctl ##1 rd_act && !ctl |=> data_oe_o)
    else $error("drive dropped during read");
  a_one_update: assert property (
    $rose(rd_act) |-> ##3 $stable(data_o))
    else $error("more than one byte per read");
endmodule

bind itmr_host_if itmr_host_if_assertions u_chk (
  .mclk_i,
  .reset_i,
  .cs_n_i,
  .rd_n_i,
  .wr_n_i,
  .port_select_hi_i,
  .port_select_lo_i,
  .data_o,
  .data_oe_o
);

// [bench/itmr_host_if_tb.sv]
module itmr_host_if_tb
  import itmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, rd_n, wr_n, oe;
  logic [1:0] port;
  logic [7:0] wdata, rdata;
  logic [2:0] cnt_clk = 3'h0;
  logic [2:0] gate = 3'h0;
  logic [2:0] out;
  int n_errors = 0;
  int total_checks = 0;
  // 125 MHz system clock
  always #4 clk = ~clk;
  itmr_cpu_model cpu (.mclk_i(clk), .rdata_i(rdata), .oe_i(oe),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .port_o(port),
    .wdata_o(wdata));
  itmr_host_if uut (.mclk_i(clk), .reset_i(reset), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .port_select_hi_i(port[1]),
    .port_select_lo_i(port[0]), .data_i(wdata), .data_o(rdata),
    .data_oe_o(oe), .cnt_clk_i(cnt_clk), .gate_i(gate), .out_o(out));
  task automatic chk(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    cpu.bus_wr(1'b0, p, d);
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] exp);
    logic [7:0] d;
    logic e;
    cpu.bus_rd(p, d, e);
    chk("drive enable", {7'h0, e}, {7'h0, p != ITMR_PORT_CTRL});
    if (p != ITMR_PORT_CTRL) chk("read data", d, exp);
  endtask
  // Counting clock pulses with the gate open, then gate closed again
  task automatic pulse(input int i, input int n);
    gate[i] = 1'b1;
    repeat (n) begin
      repeat (2) @(negedge clk);
      cnt_clk[i] = 1'b1;
      repeat (2) @(negedge clk);
      cnt_clk[i] = 1'b0;
    end
    repeat (4) @(negedge clk);
    gate[i] = 1'b0;
  endtask
  task automatic t_load;
    chk("reset enable", {7'h0, oe}, 8'h00);
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h3, 8'h71);
    wr(2'h0, 8'h12);
    wr(2'h1, 8'h00);
    wr(2'h1, 8'h01);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    pulse(1, 1);
    rd(2'h1, 8'h99);
    rd(2'h1, 8'h00);
    $display("load test done");
  endtask
  task automatic t_latch;
    wr(2'h3, 8'h00);
    pulse(0, 3);
    wr(2'h3, 8'h00);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    rd(2'h0, 8'h31);
    rd(2'h0, 8'h12);
    $display("latch test done");
  endtask
  // Every mode code, don't-care top bit included, then the cleared byte
  task automatic t_modes;
    logic [7:0] exp_b;
    for (int m = 0; m < 8; m++) begin
      exp_b = {5'h0, (m > 5) ? 3'(m - 4) : 3'(m)};
      wr(2'h3, {4'ha, 3'(m), 1'b0});
      chk("mode", {5'h0, uut.cfg_reg[2].mode}, exp_b);
      wr(2'h2, 8'h5a);
      chk("mode kept", {5'h0, uut.cfg_reg[2].mode}, exp_b);
      // Spare cycle: the new count needs two edges to reach the latch
      @(negedge clk);
      rd(2'h2, 8'h5a);
    end
    wr(2'h3, 8'h90);
    wr(2'h2, 8'h77);
    wr(2'h3, 8'hb0);
    rd(2'h2, 8'h77);
    rd(2'h2, 8'h00);
    $display("mode test done");
  endtask
  task automatic t_refuse;
    cpu.bus_wr(1'b1, 2'h1, 8'h11);
    cpu.bus_wr(1'b1, 2'h1, 8'h22);
    wr(2'h3, 8'hc2);
    rd(2'h3, 8'h00);
    rd(2'h1, 8'h99);
    rd(2'h1, 8'h00);
    $display("refusal test done");
  endtask
  // Terminal flag: cleared by the load, raised when the count hits zero
  task automatic t_out;
    wr(2'h3, 8'h90);
    wr(2'h2, 8'h02);
    @(negedge clk);
    chk("out after load", {5'h0, out}, 8'h00);
    pulse(2, 1);
    chk("out at one", {5'h0, out}, 8'h00);
    pulse(2, 1);
    chk("out at zero", {5'h0, out}, 8'h04);
    $display("output test done");
  endtask
  // Main sequence: two cycles of reset, then each scenario
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_load;
    t_latch;
    t_modes;
    t_refuse;
    t_out;
    finish_test;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test;
  end
endmodule

// [rtl/itmr_host_if.sv]
// Contract
// - Output latch follows count unless latched
// - Latch presented one byte per access
// - Count reads always come from latch
// - Bytes written singly, transferred together
// - Control word clears both count bytes
// - Writes land only in count register
// - No power-up initialisation required
// - Port three write stores control word
// - Top bits select counter or read-back
// - Access format field decode
// - Mode bits decode, don't-cares ignored
// - Low bit selects binary or BCD
// - Interleaved accesses to counters accepted
// - Count write keeps programmed mode
// - Four ports: three counters, control
// - Port select addresses counters, control
// - Strobes ignored when chip select high
// - Control port write-only, read floats
// - Second latch before read ignored
module itmr_host_if
  import itmr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_select_hi_i,
  input wire logic port_select_lo_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [ITMR_NUM_CNT-1:0] cnt_clk_i,
  input wire logic [ITMR_NUM_CNT-1:0] gate_i,
  output logic [ITMR_NUM_CNT-1:0] out_o
);

  // BCD-aware decrement of a four-decade or binary count
  function automatic logic [15:0] itmr_dec(input logic [15:0] v,
                                           input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (v[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = ITMR_DIGIT_NINE;
          end else begin
            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  itmr_bus_t bus;
  logic [1:0] port;
  logic wr_pulse, rd_pulse, wr_prev_reg, rd_prev_reg;
  logic [7:0] cw;
  logic [1:0] cw_sel;
  logic cw_write;
  itmr_cfg_t cfg_reg [ITMR_NUM_CNT];
  logic [7:0] count_register_low [ITMR_NUM_CNT];
  logic [7:0] count_register_high [ITMR_NUM_CNT];
  logic [15:0] ce_reg [ITMR_NUM_CNT];
  logic [15:0] output_latch [ITMR_NUM_CNT];
  logic [ITMR_NUM_CNT-1:0] latched_reg, wr_ptr_reg, rd_ptr_reg;
  logic [ITMR_NUM_CNT-1:0] cr_full_reg, cnt_clk_prev_reg;
  logic [ITMR_NUM_CNT-1:0] out_reg;

  // Qualify strobes by chip select; act on the falling strobe edge
  assign port = {port_select_hi_i, port_select_lo_i};
  assign bus.wr = !cs_n_i && !wr_n_i;
  assign bus.rd = !cs_n_i && !rd_n_i;
  assign bus.port = port;
  assign wr_pulse = bus.wr && !wr_prev_reg;
  assign rd_pulse = bus.rd && !rd_prev_reg && (bus.port != ITMR_PORT_CTRL);
  assign cw = data_i;
  assign cw_sel = {cw[ITMR_SEL_HI_POS], cw[ITMR_SEL_LO_POS]};
  assign cw_write = wr_pulse && (bus.port == ITMR_PORT_CTRL);

  // Strobe history for edge detection
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      cnt_clk_prev_reg <= '0;
    end else begin
      wr_prev_reg <= bus.wr;
      rd_prev_reg <= bus.rd;
      cnt_clk_prev_reg <= cnt_clk_i;
    end
  end

  // Per-counter datapath; any interleaving of ports is accepted
  for (genvar i = 0; i < ITMR_NUM_CNT; i++) begin : g_cnt
    logic sel_cw, cnt_wr, cnt_rd, latch_cmd, load, tick;
    itmr_fmt_t cw_fmt;
    assign sel_cw = cw_write && (cw_sel == 2'(i)) &&
                    (cw_sel != ITMR_SEL_READBACK);
    assign cw_fmt = itmr_fmt_t'({cw[ITMR_FMT_HI_POS], cw[ITMR_FMT_LO_POS]});
    assign latch_cmd = sel_cw && (cw_fmt == ITMR_FMT_LATCH);
    assign cnt_wr = wr_pulse && (bus.port == 2'(i));
    assign cnt_rd = rd_pulse && (bus.port == 2'(i));
    assign tick = cnt_clk_i[i] && !cnt_clk_prev_reg[i] && gate_i[i];
    assign load = cr_full_reg[i];

    // Configuration; count writes never touch the mode
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        cfg_reg[i] <= '{ITMR_FMT_LSB, ITMR_MODE0, 1'b0};
      end else if (sel_cw && !latch_cmd) begin
        cfg_reg[i].fmt <= cw_fmt;
        // Don't-care top mode bit dropped for modes 2 and 3
        cfg_reg[i].mode <= cw[ITMR_MODE_LO_POS+1] ?
          itmr_mode_t'({1'b0, cw[ITMR_MODE_HI_POS-1:ITMR_MODE_LO_POS]}) :
          itmr_mode_t'(cw[ITMR_MODE_HI_POS:ITMR_MODE_LO_POS]);
        cfg_reg[i].bcd <= cw[ITMR_BCD_POS];
      end
    end

    // Count register loading and write pointer
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        count_register_low[i] <= ITMR_BYTE_ZERO;
        count_register_high[i] <= ITMR_BYTE_ZERO;
        wr_ptr_reg[i] <= 1'b0;
        cr_full_reg[i] <= 1'b0;
      end else if (sel_cw && !latch_cmd) begin
        count_register_low[i] <= ITMR_BYTE_ZERO;
        count_register_high[i] <= ITMR_BYTE_ZERO;
        wr_ptr_reg[i] <= 1'b0;
        cr_full_reg[i] <= 1'b0;
      end else if (cnt_wr) begin
        case (cfg_reg[i].fmt)
          ITMR_FMT_LSB: begin
            count_register_low[i] <= data_i;
            cr_full_reg[i] <= 1'b1;
          end
          ITMR_FMT_MSB: begin
            count_register_high[i] <= data_i;
            cr_full_reg[i] <= 1'b1;
          end
          ITMR_FMT_BOTH: begin
            if (!wr_ptr_reg[i]) begin
              count_register_low[i] <= data_i;
              cr_full_reg[i] <= 1'b0;
            end else begin
              count_register_high[i] <= data_i;
              cr_full_reg[i] <= 1'b1;
            end
            wr_ptr_reg[i] <= !wr_ptr_reg[i];
          end
          default: begin
            cr_full_reg[i] <= cr_full_reg[i];
          end
        endcase
      end else if (load) begin
        cr_full_reg[i] <= 1'b0;
      end
    end

    // Counting element: whole-word transfer, then down count
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        ce_reg[i] <= ITMR_WORD_ZERO;
        out_reg[i] <= 1'b0;
      end else if (load) begin
        ce_reg[i] <= {count_register_high[i], count_register_low[i]};
        out_reg[i] <= 1'b0;
      end else if (tick) begin
        ce_reg[i] <= itmr_dec(ce_reg[i], cfg_reg[i].bcd);
        if (ce_reg[i] == 16'h0001) begin
          out_reg[i] <= 1'b1;
        end
      end
    end

    // Output latch follows the count until a latch command holds it
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        output_latch[i] <= ITMR_WORD_ZERO;
        latched_reg[i] <= 1'b0;
      end else if (sel_cw && !latch_cmd) begin
        latched_reg[i] <= 1'b0;
        output_latch[i] <= ce_reg[i];
      end else if (latch_cmd && !latched_reg[i]) begin
        latched_reg[i] <= 1'b1;
        output_latch[i] <= ce_reg[i];
      end else if (cnt_rd && latched_reg[i] &&
                   (cfg_reg[i].fmt != ITMR_FMT_BOTH || rd_ptr_reg[i])) begin
        latched_reg[i] <= 1'b0;
      end else if (!latched_reg[i]) begin
        output_latch[i] <= ce_reg[i];
      end
    end

    // Read byte pointer, independent of the write pointer
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        rd_ptr_reg[i] <= 1'b0;
      end else if (sel_cw && !latch_cmd) begin
        rd_ptr_reg[i] <= 1'b0;
      end else if (cnt_rd && cfg_reg[i].fmt == ITMR_FMT_BOTH) begin
        rd_ptr_reg[i] <= !rd_ptr_reg[i];
      end
    end
  end

  // One latch byte drives the bus per access; control port floats
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      data_o <= ITMR_BYTE_ZERO;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= bus.rd && (bus.port != ITMR_PORT_CTRL);
      if (rd_pulse) begin
        for (int k = 0; k < ITMR_NUM_CNT; k++) begin
          if (bus.port == 2'(k)) begin
            if (cfg_reg[k].fmt == ITMR_FMT_MSB ||
                (cfg_reg[k].fmt == ITMR_FMT_BOTH && rd_ptr_reg[k])) begin
              data_o <= output_latch[k][15:8];
            end else begin
              data_o <= output_latch[k][7:0];
            end
          end
        end
      end
    end
  end

  assign out_o = out_reg;
endmodule

// [rtl/itmr_pkg.sv]
package itmr_pkg;
  // Port map
  localparam logic [1:0] ITMR_PORT_CNT0 = 2'h0;
  localparam logic [1:0] ITMR_PORT_CNT1 = 2'h1;
  localparam logic [1:0] ITMR_PORT_CNT2 = 2'h2;
  localparam logic [1:0] ITMR_PORT_CTRL = 2'h3;
  localparam int ITMR_NUM_CNT = 3;
  // Control word field positions
  localparam int ITMR_SEL_HI_POS = 7;
  localparam int ITMR_SEL_LO_POS = 6;
  localparam int ITMR_FMT_HI_POS = 5;
  localparam int ITMR_FMT_LO_POS = 4;
  localparam int ITMR_MODE_HI_POS = 3;
  localparam int ITMR_MODE_LO_POS = 1;
  localparam int ITMR_BCD_POS = 0;
  localparam logic [1:0] ITMR_SEL_READBACK = 2'h3;
  localparam logic [7:0] ITMR_BYTE_ZERO = 8'h00;
  localparam logic [15:0] ITMR_WORD_ZERO = 16'h0000;
  localparam logic [3:0] ITMR_DIGIT_NINE = 4'h9;

  // Byte access formats
  typedef enum logic [1:0] {
    ITMR_FMT_LATCH = 2'b00,
    ITMR_FMT_LSB = 2'b01,
    ITMR_FMT_MSB = 2'b10,
    ITMR_FMT_BOTH = 2'b11
  } itmr_fmt_t;

  // Decoded operating modes
  typedef enum logic [2:0] {
    ITMR_MODE0 = 3'b000,
    ITMR_MODE1 = 3'b001,
    ITMR_MODE2 = 3'b010,
    ITMR_MODE3 = 3'b011,
    ITMR_MODE4 = 3'b100,
    ITMR_MODE5 = 3'b101
  } itmr_mode_t;

  // Per-counter programmed configuration
  typedef struct packed {
    itmr_fmt_t fmt;
    itmr_mode_t mode;
    logic bcd;
  } itmr_cfg_t;

  // Host bus strobes after qualification
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] port;
  } itmr_bus_t;
endpackage
